// file: rtl/rgcr_pkg.sv
package rgcr_pkg;
    localparam logic [7:0] RGCR_OFF_SOFT_RESET = 8'h01;
    localparam logic [7:0] RGCR_OFF_GEN_CFG = 8'h03;

    localparam int RGCR_BIT_VIDEO_RST = 4;
    localparam int RGCR_BIT_FULL_RST = 1;
    localparam int RGCR_BIT_KEEP_RST = 0;

    localparam int RGCR_BIT_CRC_EN = 7;
    localparam int RGCR_BIT_AUTO_ACK = 5;
    localparam int RGCR_BIT_FILTER_EN = 4;
    localparam int RGCR_BIT_PASS_THRU = 3;
    localparam int RGCR_BIT_OSC_AUTO = 1;

    localparam logic [7:0] RGCR_SOFT_RESET_RST = 8'h00;
    localparam logic [7:0] RGCR_GEN_CFG_RST = 8'hD2;
    localparam logic [7:0] RGCR_SOFT_RESET_MASK = 8'h13;
    localparam logic [7:0] RGCR_GEN_CFG_MASK = 8'hBA;

    // Sync filter: a level must hold this many TMDS clock enables
    localparam logic [1:0] RGCR_FILTER_CYCLES = 2'h2;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rgcr_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } rgcr_rsp_s;

    typedef struct packed {
        logic de;
        logic hs;
        logic vs;
    } rgcr_sync_s;

    // Registers returned to default by the logic-only reset
    function automatic logic rgcr_keep_rst_restores(input logic [7:0] addr);
        rgcr_keep_rst_restores = (addr == 8'h18) || (addr == 8'h19) || (addr == 8'h1A) ||
            ((addr >= 8'h48) && (addr <= 8'h55)) || (addr == 8'hC0) || (addr == 8'hC2) ||
            (addr == 8'hC3) || (addr == 8'hC6) || (addr == 8'hC8) || (addr == 8'hCE);
    endfunction
endpackage

// file: rtl/rgcr_regs.sv
`timescale 1ns/1ps
// Contract
// - Bit 4 pulses video input reset, self-clears
// - Bit 1 resets all logic and registers
// - Bit 0 resets logic, keeps registers, self-clears
// - Logic-only reset reloads strap-loaded registers
// - Logic-only reset restores fixed register list
// - Soft resets honored only in 3.3V mode
// - Bit 7 enables back-channel CRC checker
// - Bit 5 auto-acknowledges remote writes
// - Auto-ack hides remote NACK from master
// - Second port select retargets bits 5, 3
// - Bit 4 filters sync pulses under two clocks
// - Bit 3 forwards alias-matched transactions
// - Bit 1 auto-switches to internal oscillator
module rgcr_regs
    import rgcr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire rgcr_req_s req,
    output rgcr_rsp_s rsp,
    input wire logic i2c_3v3_mode,
    output logic video_input_reset,
    output logic full_logic_reset,
    output logic logic_reset_keep_regs,
    output logic strap_reload,
    output logic list_restore,
    input wire logic second_port_select,
    output logic crc_checker_en,
    output logic auto_ack_port0,
    output logic auto_ack_port1,
    output logic pass_through_port0,
    output logic pass_through_port1,
    input wire logic remote_nack,
    output logic nack_to_master,
    input wire logic alias_match,
    output logic forward_remote,
    input wire logic tmds_ce,
    input wire rgcr_sync_s sync_in,
    output rgcr_sync_s sync_out,
    input wire logic tmds_clk_present,
    output logic use_internal_osc
);
    logic [7:0] soft_rst_q;
    logic [7:0] cfg_q;
    logic rst_wr;
    logic port_auto_ack;
    logic port_pass;
    logic [2:0] raw_sync;
    logic [2:0] filt_sync;

    assign rst_wr = req.wr && (req.addr == RGCR_OFF_SOFT_RESET) && i2c_3v3_mode;

    // Self-clearing pulses, one cycle wide
    always_ff @(posedge mclk) begin
        if (rst) begin
            soft_rst_q <= RGCR_SOFT_RESET_RST;
        end else if (rst_wr) begin
            soft_rst_q <= req.wdata & RGCR_SOFT_RESET_MASK;
        end else begin
            soft_rst_q <= RGCR_SOFT_RESET_RST;
        end
    end

    assign video_input_reset = soft_rst_q[RGCR_BIT_VIDEO_RST];
    assign full_logic_reset = soft_rst_q[RGCR_BIT_FULL_RST];
    assign logic_reset_keep_regs = soft_rst_q[RGCR_BIT_KEEP_RST];
    // Strap values themselves live with their owner registers
    assign strap_reload = soft_rst_q[RGCR_BIT_KEEP_RST];
    assign list_restore = soft_rst_q[RGCR_BIT_KEEP_RST];

    // Config survives the logic-only reset: not in the restore list
    always_ff @(posedge mclk) begin
        if (rst || full_logic_reset) begin
            cfg_q <= RGCR_GEN_CFG_RST;
        end else if (req.wr && (req.addr == RGCR_OFF_GEN_CFG)) begin
            cfg_q <= req.wdata & RGCR_GEN_CFG_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rsp <= '0;
        end else begin
            rsp.valid <= req.rd;
            if (req.addr == RGCR_OFF_SOFT_RESET) begin
                rsp.rdata <= soft_rst_q & RGCR_SOFT_RESET_MASK;
            end else if (req.addr == RGCR_OFF_GEN_CFG) begin
                rsp.rdata <= cfg_q & RGCR_GEN_CFG_MASK;
            end else begin
                rsp.rdata <= 8'h00;
            end
        end
    end

    assign crc_checker_en = cfg_q[RGCR_BIT_CRC_EN];
    assign port_auto_ack = cfg_q[RGCR_BIT_AUTO_ACK];
    assign port_pass = cfg_q[RGCR_BIT_PASS_THRU];
    assign auto_ack_port0 = port_auto_ack && !second_port_select;
    assign auto_ack_port1 = port_auto_ack && second_port_select;
    assign pass_through_port0 = port_pass && !second_port_select;
    assign pass_through_port1 = port_pass && second_port_select;
    assign nack_to_master = remote_nack && !port_auto_ack;
    assign forward_remote = port_pass && alias_match;
    assign use_internal_osc = cfg_q[RGCR_BIT_OSC_AUTO] && !tmds_clk_present;

    // With bit 4 set, output follows input only once it held for two TMDS clocks; with bit 4 clear it follows on the next mclk
    assign raw_sync = {sync_in.de, sync_in.hs, sync_in.vs};
    generate
        for (genvar i = 0; i < 3; i++) begin : g_filt
            logic [1:0] cnt_q;
            logic out_q;
            // Filter state is logic, so the bit 1 and bit 0 soft resets clear it too; bit 4 does not
            always_ff @(posedge mclk) begin
                if (rst || full_logic_reset || logic_reset_keep_regs) begin
                    cnt_q <= 2'h0;
                    out_q <= 1'b0;
                end else if (!cfg_q[RGCR_BIT_FILTER_EN]) begin
                    cnt_q <= 2'h0;
                    out_q <= raw_sync[i];
                end else if (raw_sync[i] == out_q) begin
                    cnt_q <= 2'h0;
                end else if (tmds_ce) begin
                    if (cnt_q + 2'h1 >= RGCR_FILTER_CYCLES) begin
                        cnt_q <= 2'h0;
                        out_q <= raw_sync[i];
                    end else begin
                        cnt_q <= cnt_q + 2'h1;
                    end
                end
            end
            assign filt_sync[i] = out_q;
        end
    endgenerate

    assign sync_out.de = filt_sync[2];
    assign sync_out.hs = filt_sync[1];
    assign sync_out.vs = filt_sync[0];
endmodule // rgcr_regs

// file: testbench/rgcr_host.sv
`timescale 1ns/1ps
module rgcr_host import rgcr_pkg::*; (
    input wire logic mclk,
    input wire rgcr_rsp_s rsp,
    output rgcr_req_s req
);
    initial req = '0;
    task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge mclk) req <= '{w, !w, a, d};
        @(posedge mclk) req <= '0;
        #1 q = rsp.rdata;
    endtask
endmodule // rgcr_host

// file: testbench/rgcr_sva.sv
`timescale 1ns/1ps
module rgcr_sva import rgcr_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire rgcr_req_s req,
    input wire rgcr_rsp_s rsp,
    input wire logic i2c_3v3_mode,
    input wire logic full_logic_reset,
    input wire logic logic_reset_keep_regs,
    input wire logic crc_checker_en
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic [7:0] ok = req.wr && req.addr == 8'h01 && i2c_3v3_mode ? req.wdata : 8'h00;
    a_full_pulse: assert property (ok[1] |=> full_logic_reset) else $error("full");
    a_full_idle: assert property (!ok[1] |=> !full_logic_reset) else $error("full");
    a_keep_pulse: assert property (ok[0] |=> logic_reset_keep_regs) else $error("keep");
    a_keep_idle: assert property (!ok[0] |=> !logic_reset_keep_regs) else $error("keep");
    a_full_reload: assert property (full_logic_reset |=> crc_checker_en) else $error("crc");
    a_crc_off: assert property ($fell(crc_checker_en) |-> $past(req.wr)) else $error("crc");
    a_rsv_read: assert property (req.rd |=> rsp.valid && !rsp.rdata[6]) else $error("rsv");
    a_rsv_low: assert property (req.rd |=> (rsp.rdata & 8'h44) == 8'h00) else $error("rsv");
endmodule // rgcr_sva
bind rgcr_regs rgcr_sva chk_i (.*);

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb import rgcr_pkg::*;;
    logic mclk = 0, rst = 1, i2c_3v3_mode = 1, second_port_select = 0, tmds_ce = 1;
    logic remote_nack = 1, alias_match = 1, tmds_clk_present = 0, video_input_reset;
    logic full_logic_reset, logic_reset_keep_regs, strap_reload, list_restore, crc_checker_en;
    logic auto_ack_port0, auto_ack_port1, pass_through_port0, pass_through_port1;
    logic nack_to_master, forward_remote, use_internal_osc;
    logic [7:0] q;
    rgcr_req_s req;
    rgcr_rsp_s rsp;
    rgcr_sync_s sync_in = '0, sync_out;
    int err_total = 0, num_checks = 0;
    rgcr_regs dut (.*);
    rgcr_host host (.mclk, .rsp, .req);
    initial forever #2.5 mclk = ~mclk;
    task chk(input logic [7:0] s, e);
        num_checks++;
        if (s !== e) $display("BAD %0t got %h want %h", $time, s, e);
        if (s !== e) err_total++;
    endtask
    task stop_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task t_cfg;
        host.acc(0, 8'h03, 0, q);
        chk({q[7:1], use_internal_osc}, 8'h93);
        host.acc(1, 8'h03, 8'h3F, q);
        chk({auto_ack_port0, forward_remote, nack_to_master}, 3'h6);
        @(posedge mclk) second_port_select <= 1;
        #1 chk({auto_ack_port1, auto_ack_port0, crc_checker_en}, 3'h4);
        chk({pass_through_port1, pass_through_port0}, 2'h2);
    endtask
    task t_filt;
        @(posedge mclk) sync_in <= 3'h2;
        @(posedge mclk) sync_in <= 3'h0;
        repeat (3) @(posedge mclk);
        #1 chk({5'h00, sync_out}, 8'h00);
        @(posedge mclk) sync_in <= 3'h2;
        repeat (2) @(posedge mclk);
        #1 chk({5'h00, sync_out}, 8'h02);
        host.acc(1, 8'h03, 8'h00, q);
        @(posedge mclk) sync_in <= 3'h1;
        @(posedge mclk);
        #1 chk({5'h00, sync_out}, 8'h01);
    endtask
    task t_soft;
        @(posedge mclk) i2c_3v3_mode <= 0;
        host.acc(1, 8'h01, 8'h13, q);
        chk({video_input_reset, full_logic_reset, logic_reset_keep_regs}, 3'h0);
        @(posedge mclk) i2c_3v3_mode <= 1;
        host.acc(1, 8'h01, 8'h11, q);
        chk({video_input_reset, strap_reload, list_restore}, 3'h7);
        host.acc(0, 8'h03, 0, q);
        chk(q, 8'h3A);
        host.acc(1, 8'h01, 8'h02, q);
        host.acc(1, 8'h4F, 8'h02, q);
        host.acc(0, 8'h03, 0, q);
        chk(q, 8'h92);
        chk(nack_to_master, 1'b1);
        host.acc(0, 8'h4F, 0, q);
        chk(q, 8'h00);
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 0;
        t_cfg;
        t_soft;
        t_filt;
        stop_test;
    end
endmodule // tb
